// file: lvt_video_timing.sv
// video timing registers on AHB-Lite, line and frame counting, sync delay
// Function
// RQ1: line length is 12 bits; upper four in bits 3:0 of upper register.
// RQ2: lower eight line-length bits fill the register just below the upper one.
// RQ3: line length serves input channel A and output A, plus B unless single.
// RQ4: display height is 12 bits split low byte and upper nibble registers.
// RQ5: display height only acts while the test pattern generator runs.
// RQ6: each hsync or vsync is delayed by a 12-bit pixel clock count.
// RQ7: programmed delay comes on top of about ten clocks pipeline latency.
// RQ8: host must program the sync delay to at least thirty-two clocks.
// RQ9: sync delay low byte in first register, high nibble in the second.
// RQ10: hsync pulse width is a 10-bit count, low byte in a full register.
// RQ11: upper two pulse-width bits sit in bits 1:0 of the next register.
// RQ12: pairs join into values; fields reset to zero; reserved bits read zero.
`timescale 1ns/100ps
`include "lvt_regs.svh"
module lvt_video_timing (
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // video side
  input  wire logic        pix_valid,
  input  wire logic        hsync_in,
  input  wire logic        vsync_in,
  input  wire logic        tpg_enable,
  output logic             chan_a_en,
  output logic             chan_b_en,
  output logic             line_done,
  output logic             frame_done,
  output logic             hsync_out,
  output logic             vsync_out,
  output lvt_pkg::lvt_cfg_t cfg
);
  // register fields
  logic [7:0]  line_lo_ff,   nxt_line_lo;
  logic [3:0]  line_hi_ff,   nxt_line_hi;
  logic [7:0]  hgt_lo_ff,    nxt_hgt_lo;
  logic [3:0]  hgt_hi_ff,    nxt_hgt_hi;
  logic [7:0]  lag_lo_ff,    nxt_lag_lo;
  logic [3:0]  lag_hi_ff,    nxt_lag_hi;
  logic [7:0]  hpw_lo_ff,    nxt_hpw_lo;
  logic [1:0]  hpw_hi_ff,    nxt_hpw_hi;
  logic        single_ff,    nxt_single;
  // bus pipeline
  logic        wr_pend_ff,   nxt_wr_pend;
  logic [7:0]  wr_idx_ff,    nxt_wr_idx;
  logic [31:0] rdata_ff,     nxt_rdata;
  // video counters
  logic [11:0] pix_cnt_ff,   nxt_pix_cnt;
  logic [11:0] row_cnt_ff,   nxt_row_cnt;
  logic        line_done_ff, nxt_line_done;
  logic        frame_done_ff, nxt_frame_done;
  logic        hs_prev_ff,   nxt_hs_prev;
  logic        vs_prev_ff,   nxt_vs_prev;
  logic        hs_trig,      vs_trig;
  logic        lag_short;
  logic        addr_phase;
  logic [7:0]  rd_idx;
  logic        hs_busy,      vs_busy;
  lvt_pkg::lvt_cfg_t cfg_w;

  // glue an upper part and a lower byte into one timing value
  function automatic logic [11:0] join12(input logic [3:0] hi, input logic [7:0] lo);
    join12 = {hi, lo}; // RQ12
  endfunction

  // word index from byte address; upper address bits must be zero to hit
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = (a[31:10] == 22'h000000) ? a[9:2] : 8'hFF;
  endfunction

  // zero-extend a full byte field to a bus word
  function automatic logic [31:0] word_of8(input logic [7:0] f);
    word_of8 = {24'h000000, f};
  endfunction

  // zero-extend a nibble field; the register's upper bits are reserved
  function automatic logic [31:0] word_of4(input logic [3:0] f);
    word_of4 = {28'h0000000, f};
  endfunction

  // assembled configuration
  always_comb begin
    cfg_w.line_len    = join12(line_hi_ff, line_lo_ff); // RQ1 RQ2
    cfg_w.disp_height = join12(hgt_hi_ff, hgt_lo_ff); // RQ4
    cfg_w.sync_lag    = join12(lag_hi_ff, lag_lo_ff); // RQ9
    cfg_w.hpulse      = {hpw_hi_ff, hpw_lo_ff}; // RQ10 RQ11
    cfg_w.single_out  = single_ff;
  end

  assign addr_phase = hsel && htrans[1] && hready;
  assign rd_idx     = word_idx(haddr);

  // short lag only flagged, logic still runs; post-write values like every other read
  assign lag_short  = (join12(nxt_lag_hi, nxt_lag_lo) < `LVT_MIN_SYNC_LAG);

  // field updates land at the edge that ends the write data phase
  always_comb begin
    nxt_line_lo = line_lo_ff;
    nxt_line_hi = line_hi_ff;
    nxt_hgt_lo  = hgt_lo_ff;
    nxt_hgt_hi  = hgt_hi_ff;
    nxt_lag_lo  = lag_lo_ff;
    nxt_lag_hi  = lag_hi_ff;
    nxt_hpw_lo  = hpw_lo_ff;
    nxt_hpw_hi  = hpw_hi_ff;
    nxt_single  = single_ff;
    if (wr_pend_ff) begin
      case (wr_idx_ff)
        `LVT_IDX_LINE_LEN_LO: nxt_line_lo = hwdata[7:0]; // RQ2
        `LVT_IDX_LINE_LEN_HI: nxt_line_hi = hwdata[`LVT_UPPER4_MSB:0]; // RQ1
        `LVT_IDX_DISP_HGT_LO: nxt_hgt_lo  = hwdata[7:0]; // RQ4
        `LVT_IDX_DISP_HGT_HI: nxt_hgt_hi  = hwdata[`LVT_UPPER4_MSB:0]; // RQ4
        `LVT_IDX_SYNC_LAG_LO: nxt_lag_lo  = hwdata[7:0]; // RQ9
        `LVT_IDX_SYNC_LAG_HI: nxt_lag_hi  = hwdata[`LVT_UPPER4_MSB:0]; // RQ9
        `LVT_IDX_HPULSE_LO:   nxt_hpw_lo  = hwdata[7:0]; // RQ10
        `LVT_IDX_HPULSE_HI:   nxt_hpw_hi  = hwdata[`LVT_UPPER2_MSB:0]; // RQ11
        `LVT_IDX_MODE:        nxt_single  = hwdata[`LVT_SINGLE_OUT_BIT];
        default: begin
        end
      endcase
    end
  end

  // write index held over, since hwdata only arrives one cycle after the address
  always_comb begin
    nxt_wr_pend = addr_phase && hwrite;
    nxt_wr_idx  = addr_phase ? rd_idx : wr_idx_ff;
  end

  // read word from post-write values, so a read right behind a write sees it
  always_comb begin
    nxt_rdata = rdata_ff;
    if (addr_phase && !hwrite) begin
      // reserved bits and unmapped words read zero
      case (rd_idx)
        `LVT_IDX_LINE_LEN_LO: nxt_rdata = word_of8(nxt_line_lo);
        `LVT_IDX_LINE_LEN_HI: nxt_rdata = word_of4(nxt_line_hi); // RQ12
        `LVT_IDX_DISP_HGT_LO: nxt_rdata = word_of8(nxt_hgt_lo);
        `LVT_IDX_DISP_HGT_HI: nxt_rdata = word_of4(nxt_hgt_hi); // RQ12
        `LVT_IDX_SYNC_LAG_LO: nxt_rdata = word_of8(nxt_lag_lo);
        `LVT_IDX_SYNC_LAG_HI: nxt_rdata = word_of4(nxt_lag_hi); // RQ12
        `LVT_IDX_HPULSE_LO:   nxt_rdata = word_of8(nxt_hpw_lo);
        `LVT_IDX_HPULSE_HI:   nxt_rdata = word_of4({2'h0, nxt_hpw_hi}); // RQ12
        `LVT_IDX_MODE:        nxt_rdata = {27'h0000000, nxt_single, 4'h0};
        `LVT_IDX_STATUS:      nxt_rdata = {4'h0, row_cnt_ff, 4'h0, 1'b0, lag_short,
                                           vs_busy, hs_busy, pix_cnt_ff[7:0]};
        default:              nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // field registers; every field resets to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      line_lo_ff <= `LVT_RST_BYTE; // RQ12
      line_hi_ff <= 4'h0;
      hgt_lo_ff  <= `LVT_RST_BYTE;
      hgt_hi_ff  <= 4'h0;
      lag_lo_ff  <= `LVT_RST_BYTE;
      lag_hi_ff  <= 4'h0;
      hpw_lo_ff  <= `LVT_RST_BYTE;
      hpw_hi_ff  <= 2'h0;
      single_ff  <= `LVT_RST_MODE;
    end else begin
      line_lo_ff <= nxt_line_lo;
      line_hi_ff <= nxt_line_hi;
      hgt_lo_ff  <= nxt_hgt_lo;
      hgt_hi_ff  <= nxt_hgt_hi;
      lag_lo_ff  <= nxt_lag_lo;
      lag_hi_ff  <= nxt_lag_hi;
      hpw_lo_ff  <= nxt_hpw_lo;
      hpw_hi_ff  <= nxt_hpw_hi;
      single_ff  <= nxt_single;
    end
  end

  // bus pipeline registers
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_idx_ff  <= nxt_wr_idx;
    end
  end

  // read data register; stands until the next read address phase
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  // active pixel and test pattern row counting
  always_comb begin
    nxt_pix_cnt    = pix_cnt_ff;
    nxt_row_cnt    = row_cnt_ff;
    nxt_line_done  = 1'b0;
    nxt_frame_done = 1'b0;
    if (pix_valid) begin
      // zero length means no line is ever closed
      if (pix_cnt_ff + 12'h001 >= cfg_w.line_len && cfg_w.line_len != 12'h000) begin // RQ3
        nxt_pix_cnt   = 12'h000;
        nxt_line_done = 1'b1;
        if (tpg_enable) begin
          if (row_cnt_ff + 12'h001 >= cfg_w.disp_height) begin // RQ5
            nxt_row_cnt    = 12'h000;
            nxt_frame_done = 1'b1;
          end else begin
            nxt_row_cnt = row_cnt_ff + 12'h001;
          end
        end
      end else begin
        nxt_pix_cnt = pix_cnt_ff + 12'h001;
      end
    end
    // bridged video keeps the row counter idle
    if (!tpg_enable) begin
      nxt_row_cnt = 12'h000; // RQ5
    end
  end

  // counter registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pix_cnt_ff    <= 12'h000;
      row_cnt_ff    <= 12'h000;
      line_done_ff  <= 1'b0;
      frame_done_ff <= 1'b0;
    end else begin
      pix_cnt_ff    <= nxt_pix_cnt;
      row_cnt_ff    <= nxt_row_cnt;
      line_done_ff  <= nxt_line_done;
      frame_done_ff <= nxt_frame_done;
    end
  end

  // sync history; starts low, the idle level, so reset gives no false edge
  always_comb begin
    nxt_hs_prev = hsync_in;
    nxt_vs_prev = vsync_in;
  end

  // sync history registers
  always_ff @(posedge clk) begin
    if (rst) begin
      hs_prev_ff <= 1'b0;
      vs_prev_ff <= 1'b0;
    end else begin
      hs_prev_ff <= nxt_hs_prev;
      vs_prev_ff <= nxt_vs_prev;
    end
  end

  // rising edges of the incoming syncs start the delay channels
  assign hs_trig = hsync_in && !hs_prev_ff; // RQ6
  assign vs_trig = vsync_in && !vs_prev_ff; // RQ6

  // hsync: delayed rising edge, pulse width from the register pair
  lvt_sync_delay u_hs_delay (
    .clk      (clk),
    .rst      (rst),
    .trig     (hs_trig), // RQ6
    .lag      (cfg_w.sync_lag),
    .width    (cfg_w.hpulse), // RQ10
    .sync_out (hsync_out),
    .busy     (hs_busy)
  );

  // vsync: same lag, one-clock start marker since its width is held elsewhere
  lvt_sync_delay u_vs_delay (
    .clk      (clk),
    .rst      (rst),
    .trig     (vs_trig), // RQ6
    .lag      (cfg_w.sync_lag),
    .width    (10'h001),
    .sync_out (vsync_out),
    .busy     (vs_busy)
  );

  // channel B follows the same timing unless single output is chosen
  assign chan_a_en  = 1'b1; // RQ3
  assign chan_b_en  = !single_ff; // RQ3
  assign line_done  = line_done_ff;
  assign frame_done = frame_done_ff;
  assign cfg        = cfg_w;

endmodule // lvt_video_timing

// file: lvt_regs.svh
// register indices, field layout, reset values and timing counts for the video timing block
`ifndef LVT_REGS_SVH
`define LVT_REGS_SVH

// register indices; byte address is four times the index
`define LVT_IDX_LINE_LEN_LO   8'h20
`define LVT_IDX_LINE_LEN_HI   8'h21
`define LVT_IDX_DISP_HGT_LO   8'h24
`define LVT_IDX_DISP_HGT_HI   8'h25
`define LVT_IDX_SYNC_LAG_LO   8'h28
`define LVT_IDX_SYNC_LAG_HI   8'h29
`define LVT_IDX_HPULSE_LO     8'h2C
`define LVT_IDX_HPULSE_HI     8'h2D
`define LVT_IDX_MODE          8'h18
`define LVT_IDX_STATUS        8'h40

// field layout
`define LVT_UPPER4_MSB        3
`define LVT_UPPER2_MSB        1
`define LVT_SINGLE_OUT_BIT    4

// reset values
`define LVT_RST_BYTE          8'h00
`define LVT_RST_MODE          1'b0

// timing counts in pixel clocks
`define LVT_PIPE_LAT          13'h00A
`define LVT_MIN_SYNC_LAG      12'h020

`endif

// file: lvt_pkg.sv
// types shared by the video timing register block
package lvt_pkg;

  // timing values assembled from the split register pairs
  typedef struct packed {
    logic [11:0] line_len;
    logic [11:0] disp_height;
    logic [11:0] sync_lag;
    logic [9:0]  hpulse;
    logic        single_out;
  } lvt_cfg_t;

  // states of one sync delay channel
  typedef enum logic [1:0] {
    LVT_SD_IDLE  = 2'b00,
    LVT_SD_WAIT  = 2'b01,
    LVT_SD_PULSE = 2'b10
  } lvt_sd_state_t;

endpackage

// file: lvt_sync_delay.sv
// one sync delay channel: programmed lag plus pipeline latency, then a timed pulse
`timescale 1ns/100ps
`include "lvt_regs.svh"
module lvt_sync_delay (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        trig,
  input  wire logic [11:0] lag,
  input  wire logic [9:0]  width,
  output logic             sync_out,
  output logic             busy
);
  lvt_pkg::lvt_sd_state_t state_ff;
  lvt_pkg::lvt_sd_state_t nxt_state;
  logic [12:0]            cnt_ff;
  logic [12:0]            nxt_cnt;
  logic                   pulse_ff;
  logic                   nxt_pulse;
  logic [12:0]            total;

  // pipeline latency sits on top of the programmed lag; total is at least ten
  assign total = {1'b0, lag} + `LVT_PIPE_LAT; // RQ7

  // next state; a trigger while busy is dropped so one sync never stretches another
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      lvt_pkg::LVT_SD_IDLE: begin
        if (trig) begin
          nxt_state = lvt_pkg::LVT_SD_WAIT;
          nxt_cnt   = total - 13'h002; // RQ6
        end
      end
      lvt_pkg::LVT_SD_WAIT: begin
        if (cnt_ff == 13'h000) begin
          nxt_state = lvt_pkg::LVT_SD_PULSE;
          nxt_cnt   = (width == 10'h000) ? 13'h000 : {3'h0, width} - 13'h001; // RQ10
        end else begin
          nxt_cnt = cnt_ff - 13'h001;
        end
      end
      lvt_pkg::LVT_SD_PULSE: begin
        if (cnt_ff == 13'h000) begin
          nxt_state = lvt_pkg::LVT_SD_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 13'h001;
        end
      end
      default: begin
        nxt_state = lvt_pkg::LVT_SD_IDLE;
        nxt_cnt   = 13'h000;
      end
    endcase
    nxt_pulse = (nxt_state == lvt_pkg::LVT_SD_PULSE);
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= lvt_pkg::LVT_SD_IDLE;
      cnt_ff   <= 13'h000;
      pulse_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      pulse_ff <= nxt_pulse;
    end
  end

  assign sync_out = pulse_ff;
  assign busy     = (state_ff != lvt_pkg::LVT_SD_IDLE);

endmodule // lvt_sync_delay

// file: lvt_vt_checker.sv
// port-level assertions for the video timing register block
`timescale 1ns/100ps
module lvt_vt_checker (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hsync_in,
  input wire logic              tpg_enable,
  input wire logic              chan_a_en,
  input wire logic              chan_b_en,
  input wire logic              line_done,
  input wire logic              frame_done,
  input wire logic              hsync_out,
  input wire logic              vsync_out,
  input wire lvt_pkg::lvt_cfg_t cfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // read address phase decode; the data shows one cycle later
  logic       rd;
  logic [7:0] ri;
  assign rd = hsel && htrans[1] && hready && !hwrite && (haddr[31:10] == 22'h0);
  assign ri = haddr[9:2];
  // reset is checked while it is held, so no disable here
  property p_rst;
    disable iff (1'b0) rst |=> (hrdata == 32'h0) && (cfg == 47'h0);
  endproperty
  property p_len_hi; rd && ri == 8'h21 |=> hrdata == {28'h0, cfg.line_len[11:8]}; endproperty
  property p_len_lo; rd && ri == 8'h20 |=> hrdata == {24'h0, cfg.line_len[7:0]}; endproperty
  property p_hgt_hi; rd && ri == 8'h25 |=> hrdata == {28'h0, cfg.disp_height[11:8]}; endproperty
  property p_lag_lo; rd && ri == 8'h28 |=> hrdata == {24'h0, cfg.sync_lag[7:0]}; endproperty
  property p_hp_hi; rd && ri == 8'h2D |=> hrdata == {30'h0, cfg.hpulse[9:8]}; endproperty
  property p_chan; chan_a_en && (chan_b_en == !cfg.single_out); endproperty
  property p_frame; frame_done |-> line_done && $past(tpg_enable); endproperty
  // hsync_out low at the trigger, at minimum lag, must stay quiet for the eight clocks after the trigger
  property p_hs_lag;
    $rose(hsync_in) && !hsync_out && cfg.sync_lag == 12'h020 |=> !hsync_out [*8];
  endproperty
  property p_hs_w;
    $rose(hsync_out) && cfg.hpulse == 10'h003 |-> hsync_out [*3] ##1 !hsync_out;
  endproperty
  property p_vs; vsync_out |=> !vsync_out; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  a_len_hi: assert property (p_len_hi) else $error("line upper read wrong");
  a_len_lo: assert property (p_len_lo) else $error("line lower read wrong");
  a_hgt_hi: assert property (p_hgt_hi) else $error("height upper read wrong");
  a_lag_lo: assert property (p_lag_lo) else $error("lag lower read wrong");
  a_hp_hi: assert property (p_hp_hi) else $error("pulse upper read wrong");
  a_chan: assert property (p_chan) else $error("channel enables wrong");
  a_frame: assert property (p_frame) else $error("frame end outside pattern mode");
  a_hs_lag: assert property (p_hs_lag) else $error("hsync left too early");
  a_hs_w: assert property (p_hs_w) else $error("hsync width wrong");
  a_vs: assert property (p_vs) else $error("vsync longer than one cycle");
  c_line: cover property (line_done);
  c_frame: cover property (frame_done);
  c_hs: cover property ($rose(hsync_out));
endmodule // lvt_vt_checker

bind lvt_video_timing lvt_vt_checker i_lvt_vt_checker (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hsync_in(hsync_in), .tpg_enable(tpg_enable),
  .chan_a_en(chan_a_en), .chan_b_en(chan_b_en), .line_done(line_done),
  .frame_done(frame_done), .hsync_out(hsync_out), .vsync_out(vsync_out), .cfg(cfg)
);

// file: lvt_panel_model.sv
// panel side model: measures hsync pulse width and counts clocks with vsync high
`timescale 1ns/100ps
module lvt_panel_model (
  input  wire logic       clk,
  input  wire logic       hs,
  input  wire logic       vs,
  output logic [9:0]      hs_width,
  output int              vs_cnt
);
  logic [9:0] run = 10'h000;
  initial hs_width = 10'h000;
  initial vs_cnt = 0;
  // width latched when the pulse ends, so a stuck pulse never reports
  always @(posedge clk) begin
    if (hs === 1'b1) begin
      run <= run + 10'h001;
    end else begin
      if (run != 10'h000) hs_width <= run;
      run <= 10'h000;
    end
    if (vs === 1'b1) vs_cnt <= vs_cnt + 1;
  end
endmodule // lvt_panel_model

// file: lvt_video_timing_tb.sv
// self-checking bench for the video timing register block
`timescale 1ns/100ps
module lvt_video_timing_tb;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              hsel = 1'b0, hwrite = 1'b0, pix_valid = 1'b0;
  logic              hsync_in = 1'b0, vsync_in = 1'b0, tpg_enable = 1'b0;
  logic [1:0]        htrans = 2'h0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, x;
  logic              hreadyout, hresp, chan_a_en, chan_b_en;
  logic              line_done, frame_done, hsync_out, vsync_out;
  lvt_pkg::lvt_cfg_t cfg;
  logic [9:0]        hs_width;
  int                vs_cnt, err_count, n_tests, nl, nf, t1, t2;
  logic [31:0]       v [8];
  logic [7:0]        idx [8] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h28, 8'h29, 8'h2C, 8'h2D};
  logic [7:0]        msk [8] = '{8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h03};

  lvt_video_timing i_lvt_video_timing (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pix_valid(pix_valid),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .tpg_enable(tpg_enable),
    .chan_a_en(chan_a_en), .chan_b_en(chan_b_en), .line_done(line_done),
    .frame_done(frame_done), .hsync_out(hsync_out), .vsync_out(vsync_out), .cfg(cfg));
  lvt_panel_model i_lvt_panel_model (.clk(clk), .hs(hsync_out), .vs(vsync_out),
    .hs_width(hs_width), .vs_cnt(vs_cnt));

  always #2 clk = ~clk;

  // pair of split registers joined into one value
  function automatic logic [31:0] join_pair(input logic [31:0] lo, input logic [31:0] hi,
                                            input logic [7:0] m);
    return {16'h0, hi[7:0] & m, lo[7:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // bounded wait for an edge that samples ready high
  task automatic tick();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      tally_and_finish();
    end
  endtask

  // one single word transfer; byte address is four times the index
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {22'h0, i, 2'h0};
    tick();
    htrans <= 2'h0;
    hwdata <= d;
    tick();
    r = hrdata;
  endtask

  // raise a sync input, count clocks until the delayed copy appears
  task automatic meas(input logic vs, output int n);
    n = 0;
    if (vs) vsync_in <= 1'b1;
    else hsync_in <= 1'b1;
    // output read at the edge shows what the edge before launched
    do begin
      @(posedge clk);
      n++;
    end while ((vs ? vsync_out : hsync_out) !== 1'b1 && n < 500);
    if (n >= 500) begin
      err_count++;
      tally_and_finish();
    end
    hsync_in <= 1'b0;
    vsync_in <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  // k lines of len pixels with random gaps
  task automatic lines(input int k, input int len);
    int p;
    logic pv;
    p = 0;
    nl = 0;
    nf = 0;
    repeat (k * len * 3 + 4) begin
      pv = (p < k * len) ? 1'($urandom_range(0, 1)) : 1'b0;
      pix_valid <= pv;
      @(posedge clk);
      p += pv;
      nl += (line_done === 1'b1);
      nf += (frame_done === 1'b1);
    end
    // one idle edge more, so a pulse from the very last pixel is still counted
    pix_valid <= 1'b0;
    @(posedge clk);
    nl += (line_done === 1'b1);
    nf += (frame_done === 1'b1);
    if (p != k * len) begin
      err_count++;
      tally_and_finish();
    end
  endtask

  initial begin
    void'($urandom(32'hB6E1));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (idx[i]) begin
      bus(1'b0, idx[i], 32'h0, x);
      chk(x, 32'h0);
    end
    bus(1'b0, 8'h3F, 32'h0, x);
    chk(x, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("reset values done");
    foreach (idx[i]) begin
      v[i] = $urandom();
      bus(1'b1, idx[i], v[i], x);
      bus(1'b0, idx[i], 32'h0, x);
      chk(x, v[i] & {24'h0, msk[i]});
    end
    @(posedge clk);
    chk({20'h0, cfg.line_len}, join_pair(v[0], v[1], 8'h0F));
    chk({20'h0, cfg.disp_height}, join_pair(v[2], v[3], 8'h0F));
    chk({20'h0, cfg.sync_lag}, join_pair(v[4], v[5], 8'h0F));
    chk({22'h0, cfg.hpulse}, join_pair(v[6], v[7], 8'h03));
    $display("register fields done");
    bus(1'b1, 8'h18, 32'h10, x);
    bus(1'b0, 8'h18, 32'h0, x);
    chk(x, 32'h10);
    @(posedge clk);
    chk({30'h0, chan_a_en, chan_b_en}, 32'h2);
    bus(1'b1, 8'h18, 32'h0, x);
    @(posedge clk);
    chk({30'h0, chan_a_en, chan_b_en}, 32'h3);
    $display("channel mode done");
    bus(1'b1, 8'h20, 32'h5, x);
    bus(1'b1, 8'h21, 32'h0, x);
    bus(1'b1, 8'h24, 32'h2, x);
    bus(1'b1, 8'h25, 32'h0, x);
    lines(3, 5);
    chk(nl, 3);
    chk(nf, 0);
    tpg_enable <= 1'b1;
    lines(4, 5);
    chk(nl, 4);
    chk(nf, 32'h2);
    tpg_enable <= 1'b0;
    $display("line and frame done");
    bus(1'b1, 8'h28, 32'h14, x);
    bus(1'b1, 8'h29, 32'h0, x);
    bus(1'b0, 8'h40, 32'h0, x);
    chk({31'h0, x[10]}, 32'h1);
    bus(1'b1, 8'h28, 32'h20, x);
    bus(1'b0, 8'h40, 32'h0, x);
    chk({31'h0, x[10]}, 32'h0);
    bus(1'b1, 8'h2C, 32'h3, x);
    bus(1'b1, 8'h2D, 32'h0, x);
    meas(1'b0, t1);
    chk(hs_width, 10'h003);
    chk(32'(t1 >= 40 && t1 <= 45), 32'h1);
    bus(1'b1, 8'h28, 32'h64, x);
    meas(1'b0, t2);
    chk(t2 - t1, 32'h44);
    meas(1'b1, t1);
    chk(t1, t2);
    chk(vs_cnt, 1);
    $display("sync delay done");
    tally_and_finish();
  end
endmodule // lvt_video_timing_tb
